// ===== include/branch_misc_pkg.sv
// Constants, types and the state record of the branch and miscellaneous
// instruction execution block. Assumes a 32-bit APB slave port, byte addresses.
package branch_misc_pkg;

  // Register byte addresses
  localparam logic [7:0] A_CMD  = 8'h00;
  localparam logic [7:0] A_OPND = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_ACC  = 8'h0C;
  localparam logic [7:0] A_PC   = 8'h10;
  localparam logic [7:0] A_TABLE_READ_UPPER = 8'h14;
  localparam logic [7:0] A_WDT  = 8'h18;
  localparam logic [7:0] A_MADR = 8'h1C;
  localparam logic [7:0] A_MDAT = 8'h20;
  localparam logic [7:0] A_WAKE = 8'h24;

  // Command word fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_M_LSB   = 8;
  localparam int CMD_BIT_LSB = 16;

  // Status word fields
  localparam int ST_BUSY_B = 0;
  localparam int ST_SLP_B  = 1;
  localparam int ST_TO_B   = 2;
  localparam int ST_PD_B   = 3;
  localparam int ST_SKIP_B = 4;
  localparam int ST_PRE1_B = 5;
  localparam int ST_PRE2_B = 6;
  localparam int ST_SP_LSB = 8;

  // Special data bytes and timing
  localparam logic [5:0] PCL_ADDR     = 6'h06;
  localparam logic [5:0] TBLP_ADDR    = 6'h07;
  localparam logic [3:0] LAST_PAGE    = 4'hF;
  localparam logic [7:0] WDT_MAX      = 8'hFF;
  localparam logic [1:0] PRESC_LAST   = 2'h3;
  localparam int         CLK_PER_ICYC = 4;

  typedef enum logic [4:0] {
    OP_BRANCH = 5'h00, OP_SKIP_CLEAR = 5'h01, OP_COPY_TEST = 5'h02,
    OP_BIT_LOW = 5'h03, OP_BIT_HIGH = 5'h04, OP_INCR_SKIP = 5'h05,
    OP_DECR_SKIP = 5'h06, OP_INCR_ACC = 5'h07, OP_DECR_ACC = 5'h08,
    OP_CALL = 5'h09, OP_SUB_EXIT = 5'h0A, OP_SUB_EXIT_IMM = 5'h0B,
    OP_IRQ_EXIT = 5'h0C, OP_TBL_CUR = 5'h0D, OP_TBL_FINAL = 5'h0E,
    OP_IDLE = 5'h0F, OP_BYTE_ZERO = 5'h10, OP_BYTE_ONES = 5'h11,
    OP_WD_RESTART = 5'h12, OP_WD_FIRST = 5'h13, OP_WD_SECOND = 5'h14,
    OP_NIB_EXCH = 5'h15, OP_NIB_EXCH_ACC = 5'h16, OP_SLEEP = 5'h17
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_EXEC = 3'b010, ST_SLEEP = 3'b100
  } fsm_t;

  typedef struct packed {
    fsm_t             st;
    logic [3:0]       cyc;
    logic [1:0]       presc;
    logic [7:0]       wdt;
    logic             to_f;
    logic             pd_f;
    logic             pre1;
    logic             pre2;
    logic             skip;
    logic             sleep_pend;
    logic             tbl_pend;
    logic [5:0]       dst;
    logic [7:0]       acc;
    logic [11:0]      pc;
    logic [11:0]      prog_addr;
    logic [6:0]       table_read_upper;
    logic [2:0]       sp;
    logic [7:0][11:0] stack;
    logic [63:0][7:0] mem;
    logic [11:0]      opnd;
    logic [5:0]       madr;
    logic [31:0]      rdata;
  } core_state_t;

  localparam core_state_t STATE_RST = '{st: ST_IDLE, default: '0};

endpackage

// ===== hdl/branch_misc_exec.sv
// Execution unit for the branch, skip, table read and miscellaneous groups
// of a small 8-bit core, driven one instruction at a time over APB.
// Assumes program memory answers a registered address on the next clock.
//
// Function
// [RULE1] Skip-if-zero runs next only if byte nonzero
// [RULE2] Copy byte to accumulator, skip when zero
// [RULE3] Bit tests skip on zero, or one
// [RULE4] Bit select addresses bits zero to seven
// [RULE5] Increment to memory, skip on zero, both penalties
// [RULE6] Decrement to memory, skip on zero, both penalties
// [RULE7] Accumulator forms keep memory, skip on zero
// [RULE8] A taken skip adds one instruction cycle
// [RULE9] Program-counter-low destination adds one cycle
// [RULE10] Call and returns take two cycles
// [RULE11] Current-page table read fills byte and upper
// [RULE12] Final-page table read, same, two cycles
// [RULE13] Completed pre-clear pair clears both flags
// [RULE14] Lone pre-clear leaves both flags unchanged
// [RULE15] Nibble exchange in place, one cycle
// [RULE16] Nibble exchange into accumulator, byte untouched
// [RULE17] Sleep takes one cycle, updates both flags
// [RULE18] Listed instructions change no status flag
// [RULE19] Watchdog restart zeroes count, clears flags
// [RULE20] Sleep stops, clears watchdog, sets sleep flag
// [RULE21] Call pushes next address, loads target
// [RULE22] Branch takes two cycles; idle does nothing
// [RULE23] Byte zero or ones, one cycle plus penalty
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/10ps

module branch_misc_exec
  import branch_misc_pkg::*;
(
  input  wire logic        core_clk,             // System clock, 25 MHz
  input  wire logic        rstn,                 // Synchronous reset, active low
  input  wire logic        psel,                 // APB select
  input  wire logic        penable,              // APB access phase
  input  wire logic        pwrite,               // APB direction, high for write
  input  wire logic [7:0]  paddr,                // APB byte address
  input  wire logic [31:0] pwdata,               // APB write data
  output logic      [31:0] prdata,               // APB read data, registered
  output logic             pready,               // APB ready, never stalls
  output logic             pslverr,              // APB error on bad access
  output logic      [11:0] prog_addr,            // Program memory word address
  input  wire logic [14:0] prog_data,            // Program memory word
  output logic             busy,                 // Instruction in progress
  output logic             sleeping,             // Execution and clock stopped
  output logic             watchdog_expiry_flag, // Watchdog timeout flag
  output logic             sleep_entered_flag    // Power-down flag
);

  core_state_t s;
  core_state_t n;

  logic        acc_ph;
  logic        wr_acc;
  logic        tick;
  logic        ovf;
  logic        we;
  logic [5:0]  wa;
  logic [7:0]  wv;
  logic        wd_clr;
  logic        skip;
  logic        pcl_pen;
  logic [1:0]  icyc;
  logic [5:0]  m;
  logic [2:0]  bsel;
  logic [7:0]  mv;
  logic [7:0]  inc_v;
  logic [7:0]  dec_v;
  logic [11:0] pc_inc;

  // Data byte read; the low program counter byte stands in its slot
  function automatic logic [7:0] rd_byte(input core_state_t st, input logic [5:0] a);
    return (a == PCL_ADDR) ? st.pc[7:0] : st.mem[a];
  endfunction

  // Exchange the two nibbles of a byte
  function automatic logic [7:0] nib_x(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  // Address decode, shared by write strobe and error answer
  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      A_CMD, A_OPND, A_STAT, A_ACC, A_PC, A_TABLE_READ_UPPER, A_WDT, A_MADR, A_MDAT, A_WAKE:
        return 1'b1;
      default:
        return 1'b0;
    endcase
  endfunction

  // Read multiplexer; write-only registers read as zero
  function automatic logic [31:0] rd_mux(input core_state_t st, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      A_OPND: r[11:0] = st.opnd;
      A_STAT: begin
        r[ST_BUSY_B]            = (st.st == ST_EXEC);
        r[ST_SLP_B]             = (st.st == ST_SLEEP);
        r[ST_TO_B]              = st.to_f;
        r[ST_PD_B]              = st.pd_f;
        r[ST_SKIP_B]            = st.skip;
        r[ST_PRE1_B]            = st.pre1;
        r[ST_PRE2_B]            = st.pre2;
        r[ST_SP_LSB +: 3]       = st.sp;
      end
      A_ACC:  r[7:0]  = st.acc;
      A_PC:   r[11:0] = st.pc;
      A_TABLE_READ_UPPER: r[6:0]  = st.table_read_upper;
      A_WDT:  r[7:0]  = st.wdt;
      A_MADR: r[5:0]  = st.madr;
      A_MDAT: r[7:0]  = st.mem[st.madr];
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // Bus phases and command fields
  assign acc_ph = psel && penable;
  assign wr_acc = acc_ph && pwrite && addr_ok(paddr);
  assign m      = pwdata[CMD_M_LSB +: 6];
  assign bsel   = pwdata[CMD_BIT_LSB +: 3]; // RULE4
  assign mv     = rd_byte(s, m);
  assign inc_v  = mv + 8'h01;
  assign dec_v  = mv - 8'h01;
  assign pc_inc = s.pc + 12'h001;

  // Zero-wait slave: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign prdata  = s.rdata;
  assign pslverr = acc_ph && (!addr_ok(paddr) ||
                   (pwrite && paddr == A_CMD && s.st != ST_IDLE));

  assign prog_addr            = s.prog_addr;
  assign busy                 = (s.st == ST_EXEC);
  assign sleeping             = (s.st == ST_SLEEP); // RULE20
  assign watchdog_expiry_flag = s.to_f;
  assign sleep_entered_flag   = s.pd_f;

  // Next-state logic: prescaler, watchdog, sequencing, bus and instructions
  always_comb begin
    n       = s;
    we      = 1'b0;
    wa      = m;
    wv      = 8'h00;
    wd_clr  = 1'b0;
    skip    = 1'b0;
    pcl_pen = 1'b0;
    icyc    = 2'd1;

    // The prescaler only runs while the system clock would run
    tick = (s.st != ST_SLEEP) && (s.presc == PRESC_LAST);
    ovf  = tick && (s.wdt == WDT_MAX);
    if (s.st != ST_SLEEP) begin
      n.presc = s.presc + 2'h1;
    end
    if (tick) begin
      n.wdt = s.wdt + 8'h01;
    end

    // Count out the clocks of the running instruction
    case (s.st)
      ST_IDLE: begin
      end
      ST_EXEC: begin
        if (s.cyc == 4'h0) begin
          n.st         = s.sleep_pend ? ST_SLEEP : ST_IDLE;
          n.sleep_pend = 1'b0;
        end else begin
          n.cyc = s.cyc - 4'h1;
        end
      end
      ST_SLEEP: begin
      end
      default: n.st = ST_IDLE;
    endcase

    // Table word arrives one clock after its address was registered
    if (s.tbl_pend) begin
      n.tbl_pend = 1'b0;
      n.table_read_upper     = prog_data[14:8]; // RULE11 RULE12
      we         = 1'b1;
      wa         = s.dst;
      wv         = prog_data[7:0];
    end

    // Read data is latched in the setup cycle so prdata comes from a flop
    if (psel && !penable) begin
      n.rdata = rd_mux(s, paddr);
    end

    if (wr_acc) begin
      case (paddr)
        A_OPND: n.opnd = pwdata[11:0];
        A_ACC:  n.acc  = pwdata[7:0];
        A_MADR: n.madr = pwdata[5:0];
        A_MDAT: n.mem[s.madr] = pwdata[7:0];
        A_WAKE: begin
          if (s.st == ST_SLEEP) begin
            n.st = ST_IDLE;
          end
        end
        A_CMD: begin
          // Commands are refused while busy or asleep
          if (s.st == ST_IDLE) begin
            n.pc = pc_inc;
            case (op_t'(pwdata[CMD_OP_LSB +: 5]))
              OP_BRANCH: begin
                icyc = 2'd2; // RULE22
                n.pc = s.opnd;
              end
              OP_SKIP_CLEAR: skip = (mv == 8'h00); // RULE1
              OP_COPY_TEST: begin
                n.acc = mv; // RULE2
                skip  = (mv == 8'h00);
              end
              OP_BIT_LOW:  skip = !mv[bsel]; // RULE3
              OP_BIT_HIGH: skip = mv[bsel];  // RULE3
              OP_INCR_SKIP: begin
                we   = 1'b1; // RULE5
                wv   = inc_v;
                skip = (inc_v == 8'h00);
              end
              OP_DECR_SKIP: begin
                we   = 1'b1; // RULE6
                wv   = dec_v;
                skip = (dec_v == 8'h00);
              end
              OP_INCR_ACC: begin
                n.acc = inc_v; // RULE7
                skip  = (inc_v == 8'h00);
              end
              OP_DECR_ACC: begin
                n.acc = dec_v; // RULE7
                skip  = (dec_v == 8'h00);
              end
              OP_CALL: begin
                icyc          = 2'd2; // RULE10
                n.stack[s.sp] = pc_inc; // RULE21
                n.sp          = s.sp + 3'h1;
                n.pc          = s.opnd;
              end
              OP_SUB_EXIT, OP_IRQ_EXIT: begin
                icyc = 2'd2; // RULE10
                n.sp = s.sp - 3'h1;
                n.pc = s.stack[s.sp - 3'h1];
              end
              OP_SUB_EXIT_IMM: begin
                icyc  = 2'd2; // RULE10
                n.sp  = s.sp - 3'h1;
                n.pc  = s.stack[s.sp - 3'h1];
                n.acc = s.opnd[7:0];
              end
              OP_TBL_CUR: begin
                icyc        = 2'd2; // RULE11
                n.prog_addr = {s.pc[11:8], rd_byte(s, TBLP_ADDR)};
                n.tbl_pend  = 1'b1;
                n.dst       = m;
                pcl_pen     = (m == PCL_ADDR);
              end
              OP_TBL_FINAL: begin
                icyc        = 2'd2; // RULE12
                n.prog_addr = {LAST_PAGE, rd_byte(s, TBLP_ADDR)};
                n.tbl_pend  = 1'b1;
                n.dst       = m;
                pcl_pen     = (m == PCL_ADDR);
              end
              OP_BYTE_ZERO: begin
                we = 1'b1; // RULE23
                wv = 8'h00;
              end
              OP_BYTE_ONES: begin
                we = 1'b1; // RULE23
                wv = 8'hFF;
              end
              OP_WD_RESTART: wd_clr = 1'b1; // RULE19
              OP_WD_FIRST: begin
                // The pair may complete in either order
                if (s.pre2) begin
                  wd_clr = 1'b1; // RULE13
                end else begin
                  n.pre1 = 1'b1; // RULE14
                end
              end
              OP_WD_SECOND: begin
                if (s.pre1) begin
                  wd_clr = 1'b1; // RULE13
                end else begin
                  n.pre2 = 1'b1; // RULE14
                end
              end
              OP_NIB_EXCH: begin
                we = 1'b1; // RULE15
                wv = nib_x(mv);
              end
              OP_NIB_EXCH_ACC: n.acc = nib_x(mv); // RULE16
              OP_SLEEP: begin
                n.sleep_pend = 1'b1; // RULE17 RULE20
                n.pd_f       = 1'b1;
                n.to_f       = 1'b0;
                n.wdt        = 8'h00;
                n.presc      = 2'h0;
              end
              // Idle and unknown codes: one cycle, nothing else moves
              default: icyc = 2'd1; // RULE22 RULE18
            endcase
            if (we && m == PCL_ADDR) begin
              pcl_pen = 1'b1; // RULE9
            end
            if (skip) begin
              n.pc = s.pc + 12'h002; // RULE1
            end
            n.skip = skip;
            n.st   = ST_EXEC;
            // Each extra instruction cycle is four more system clocks
            n.cyc  = 4'((32'(icyc) + 32'(skip) + 32'(pcl_pen)) * CLK_PER_ICYC - 1); // RULE8 RULE9
          end
        end
        default: begin
        end
      endcase
    end

    // One byte write port; the low program counter byte is mapped in
    if (we) begin
      if (wa == PCL_ADDR) begin
        n.pc = {n.pc[11:8], wv}; // RULE9
      end else begin
        n.mem[wa] = wv;
      end
    end

    // Watchdog clear also restarts the prescaler and drops any half pair
    if (wd_clr) begin
      n.wdt   = 8'h00; // RULE19 RULE13
      n.presc = 2'h0;
      n.to_f  = 1'b0;
      n.pd_f  = 1'b0;
      n.pre1  = 1'b0;
      n.pre2  = 1'b0;
    end

    // A timeout in the same clock as a clear still lands
    if (ovf) begin
      n.to_f = 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

endmodule

// ===== testbench/branch_misc_exec_props.sv
// Port-level checker for the branch and miscellaneous execution block.
// Sees only the top module's ports; bound to every instance at the foot.
`timescale 1ns/10ps
module branch_misc_props
  import branch_misc_pkg::*;
(
  input wire logic        core_clk,             // Clock
  input wire logic        rstn,                 // Reset, low
  input wire logic        psel,                 // Select
  input wire logic        penable,              // Access phase
  input wire logic        pwrite,               // Write
  input wire logic [7:0]  paddr,                // Address
  input wire logic [31:0] pwdata,               // Write data
  input wire logic [31:0] prdata,               // Read data
  input wire logic        pslverr,              // Error
  input wire logic        busy,                 // Busy
  input wire logic        sleeping,             // Asleep
  input wire logic        watchdog_expiry_flag, // Timeout flag
  input wire logic        sleep_entered_flag    // Power-down flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic       take_w;
  logic [4:0] bcnt_r;
  logic [4:0] bcnt_nxt;
  logic [4:0] lop_r;
  logic [4:0] lop_nxt;
  // Accepted command, and the opcode it carried
  assign take_w = psel && penable && pwrite && paddr == A_CMD && !busy && !sleeping;
  // Busy run length; a run must be whole instruction cycles
  always_comb begin
    bcnt_nxt = busy ? bcnt_r + 5'h01 : 5'h00;
    lop_nxt  = take_w ? pwdata[4:0] : lop_r;
  end
  always_ff @(posedge core_clk) begin
    bcnt_r <= rstn ? bcnt_nxt : 5'h00;
    lop_r  <= rstn ? lop_nxt : 5'h00;
  end
  sequence cmd_wr;
    psel && penable && pwrite && paddr == A_CMD;
  endsequence
  sequence cmd_take;
    cmd_wr ##0 take_w;
  endsequence
  start_busy_a: assert property (cmd_take |=> busy)
    else $error("busy did not follow an accepted command");
  busy_len_a: assert property ($fell(busy) |-> bcnt_r inside {4, 8, 12, 16})
    else $error("busy run is not whole instruction cycles");
  cmd_refuse_a: assert property (cmd_wr ##0 (busy || sleeping) |-> pslverr)
    else $error("command while busy not refused");
  unmapped_err_a: assert property (psel && penable && paddr > 8'h24 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");
  sleep_flags_a: assert property ($rose(sleeping) |-> sleep_entered_flag && !watchdog_expiry_flag)
    else $error("sleep entered with wrong flags");
  pd_rise_a: assert property ($rose(sleep_entered_flag) |-> $past(take_w) && lop_r == 5'h17)
    else $error("power-down flag set without sleep");
  pd_fall_a: assert property ($fell(sleep_entered_flag) |-> $past(take_w) && lop_r inside {5'h12, 5'h13, 5'h14})
    else $error("power-down flag cleared by other command");
  to_fall_a: assert property ($fell(watchdog_expiry_flag) |-> $past(take_w) && lop_r inside {5'h12, 5'h13, 5'h14, 5'h17})
    else $error("timeout flag cleared by other command");
  sleep_hold_a: assert property (sleeping && !(psel && penable && pwrite && paddr == A_WAKE) |=> sleeping)
    else $error("left sleep without wake");
endmodule

bind branch_misc_exec branch_misc_props u_props (.*);

// ===== testbench/tb.sv
// Self-checking bench: random and corner instructions issued over APB.
// Program memory is modelled as a fixed function of the word address.
`timescale 1ns/10ps
module tb
  import branch_misc_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] prog_addr;
  logic [14:0] prog_data;
  logic        busy;
  logic        sleeping;
  logic        watchdog_expiry_flag;
  logic        sleep_entered_flag;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          nclk;
  logic [31:0] rd;
  logic        err;

  branch_misc_exec dut (.*);

  initial forever #20 core_clk = ~core_clk;

  function automatic logic [14:0] pw(input logic [11:0] x);
    return {x[11:5], x[7:0]} ^ 15'h2B5C;
  endfunction

  // Word follows the registered address at once, so it is valid on the next clock
  always_comb prog_data = pw(prog_addr);

  // Hang guard; the run needs well under this many clocks
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // Issue one instruction and count the clocks busy stays high
  task automatic run(input logic [4:0] op, input logic [5:0] m, input logic [2:0] b);
    xfer(1'b1, A_CMD, {13'h0, b, 2'h0, m, 3'h0, op});
    nclk = 0;
    #1;
    while (busy === 1'b1 && nclk < 40) begin
      nclk++;
      @(posedge core_clk);
      #1;
    end
  endtask

  // Sleep, a refused command, then wake; power-down flag stays set
  task automatic nap();
    run(5'h17, 6'h0, 3'h0);
    chk(32'(nclk), 32'h4);
    xfer(1'b1, A_CMD, 32'h0F);
    chk(32'(err), 32'h1);
    rck(A_STAT, 32'hF, 32'hA);
    xfer(1'b1, A_WAKE, 32'h0);
    rck(A_STAT, 32'hF, 32'h8);
  endtask

  // Expected skip, byte and accumulator of one instruction
  function automatic void model(input logic [4:0] op, input logic [7:0] v, a,
                                input logic [2:0] b, output logic sk,
                                output logic [7:0] nv, na);
    nv = v;
    na = a;
    case (op)
      5'h02: na = v;
      5'h05: nv = v + 8'h01;
      5'h06: nv = v - 8'h01;
      5'h07: na = v + 8'h01;
      5'h08: na = v - 8'h01;
      5'h10: nv = 8'h00;
      5'h11: nv = 8'hFF;
      5'h15: nv = {v[3:0], v[7:4]};
      5'h16: na = {v[3:0], v[7:4]};
      default: ;
    endcase
    case (op)
      5'h01, 5'h02: sk = v == 8'h00;
      5'h03: sk = !v[b];
      5'h04: sk = v[b];
      5'h05, 5'h06: sk = nv == 8'h00;
      5'h07, 5'h08: sk = na == 8'h00;
      default: sk = 1'b0;
    endcase
  endfunction

  initial begin
    logic [4:0]  ops[13] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
                             5'h08, 5'h0F, 5'h10, 5'h11, 5'h15, 5'h16};
    logic [4:0]  xop[3] = '{5'h0A, 5'h0B, 5'h0C};
    logic [7:0]  cv[4] = '{8'h00, 8'h00, 8'hFF, 8'h01};
    logic [7:0]  v, a, nv, na;
    logic [5:0]  m;
    logic [2:0]  b, s0;
    logic        sk;
    logic [11:0] ea;
    void'($urandom(32'hd7f1));
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    rck(8'h30, 32'hFFFFFFFF, 32'h0);
    chk(32'(err), 32'h1);
    // Back-to-back commands: the second lands while busy
    xfer(1'b1, A_CMD, 32'h0F);
    xfer(1'b1, A_CMD, 32'h0F);
    chk(32'(err), 32'h1);
    repeat (8) @(posedge core_clk);
    // Every data op with random and boundary bytes; sleep keeps the watchdog fresh
    for (int i = 0; i < 26; i++) begin
      if (i % 8 == 0) nap();
      v = (i % 4 == 0) ? 8'($urandom) : cv[i % 4];
      a = 8'($urandom);
      m = 6'($urandom_range(63, 8));
      b = 3'($urandom);
      xfer(1'b1, A_MADR, 32'(m));
      xfer(1'b1, A_MDAT, 32'(v));
      xfer(1'b1, A_ACC, 32'(a));
      model(ops[i % 13], v, a, b, sk, nv, na);
      run(ops[i % 13], m, b);
      chk(32'(nclk), sk ? 32'h8 : 32'h4);
      rck(A_STAT, 32'h1C, {27'h0, sk, 4'h8});
      rck(A_MDAT, 32'hFF, 32'(nv));
      rck(A_ACC, 32'hFF, 32'(na));
    end
    // Writes to program-counter-low pay one more cycle
    for (int j = 0; j < 4; j++) begin
      run(ops[j + 9], PCL_ADDR, 3'h0);
      chk(32'(nclk), j == 3 ? 32'h4 : 32'h8);
    end
    rck(A_STAT, 32'h0, 32'h0);
    s0 = rd[10:8];
    xfer(1'b1, A_ACC, 32'h11);
    for (int j = 0; j < 3; j++) begin
      xfer(1'b1, A_OPND, 32'h3A5);
      run(5'h00, 6'h0, 3'h0);
      chk(32'(nclk), 32'h8);
      rck(A_PC, 32'hFFF, 32'h3A5);
      xfer(1'b1, A_OPND, 32'h5C0);
      run(5'h09, 6'h0, 3'h0);
      chk(32'(nclk), 32'h8);
      rck(A_PC, 32'hFFF, 32'h5C0);
      rck(A_STAT, 32'h700, {21'h0, 3'(s0 + 3'h1), 8'h0});
      xfer(1'b1, A_OPND, 32'h0E7);
      run(xop[j], 6'h0, 3'h0);
      chk(32'(nclk), 32'h8);
      rck(A_PC, 32'hFFF, 32'h3A6);
      rck(A_ACC, 32'hFF, j == 0 ? 32'h11 : 32'hE7);
    end
    xfer(1'b1, A_MADR, 32'(TBLP_ADDR));
    xfer(1'b1, A_MDAT, 32'h9D);
    for (int j = 0; j < 2; j++) begin
      ea = {j == 1 ? LAST_PAGE : 4'h3, 8'h9D};
      run(5'h0D + 5'(j), 6'h2A, 3'h0);
      chk(32'(nclk), 32'h8);
      chk(32'(prog_addr), 32'(ea));
      xfer(1'b1, A_MADR, 32'h2A);
      rck(A_MDAT, 32'hFF, 32'(pw(ea) & 15'hFF));
      rck(A_TABLE_READ_UPPER, 32'h7F, 32'(pw(ea) >> 8));
    end
    // Let the watchdog expire, then clear by the pair and by the single form
    nap();
    repeat (1100) @(posedge core_clk);
    run(5'h13, 6'h0, 3'h0);
    chk(32'(nclk), 32'h4);
    rck(A_STAT, 32'h6C, 32'h2C);
    run(5'h14, 6'h0, 3'h0);
    rck(A_STAT, 32'h6C, 32'h0);
    nap();
    repeat (1100) @(posedge core_clk);
    rck(A_STAT, 32'hC, 32'hC);
    run(5'h12, 6'h0, 3'h0);
    rck(A_STAT, 32'hC, 32'h0);
    rck(A_WDT, 32'hFC, 32'h0);
    print_verdict();
  end
endmodule
